/* File: hdl/ics_pkg.sv */
// Contract
// - Nine-line buses: byte plus odd parity
// - Line 7 is LSB, line 0 MSB
// - Bus-in valid 100 ns after tag, held; code loads bus-in two cycles before its tag rises
// - Inbound tag identifies bus-in contents
// - Claim with op-in or pass select-out
// - After passing, no op-in until next poll
// - Claiming unit blocks select-out, sends address
// - Hold op-in until select-out drops
// - Last unit returns select-out as select-in
// - Option: logic in select-out or select-in chain
// - Raise request-in before next poll
// - Without hold-out only forward select-out
// - Decode address; matching idle unit claims
// - Halt address-out means disconnect
// - Drop op-in within 6 us of disconnect
// - Busy unit answers with status-in
// - One inbound tag at a time, held
// - Ignore outbound tags without operational-out; code gates only address-, command- and service-out, not select-out or hold-out
package ics_pkg;
	localparam int          ICS_CLK_MHZ      = 10;
	localparam int          ICS_BUS_SETUP_NS = 100;
	localparam int          ICS_SETUP_CYC    = (ICS_BUS_SETUP_NS * ICS_CLK_MHZ + 999) / 1000;
	localparam int          ICS_DISC_US      = 6;
	localparam int          ICS_DISC_CYC     = ICS_DISC_US * ICS_CLK_MHZ;
	localparam int          ICS_FIFO_DEPTH   = 32;
	localparam int          ICS_FIFO_WIDTH   = 8;
	localparam logic [3:0]  ICS_CNT_ZERO     = 4'h0;
	localparam logic [3:0]  ICS_SETUP_CNT    = 4'(ICS_SETUP_CYC);
	localparam logic [7:0]  ICS_DISC_CNT     = 8'(ICS_DISC_CYC);
	localparam logic [7:0]  ICS_BYTE_ZERO    = 8'h00;

	typedef enum logic [2:0] {
		ICS_IDLE = 3'b000,
		ICS_SETUP = 3'b001,
		ICS_TAG = 3'b010,
		ICS_WAIT_DROP = 3'b011,
		ICS_HOLD = 3'b100,
		ICS_DISC = 3'b101
	} ics_state_e;

	typedef enum logic [1:0] {
		ICS_TAG_ADDR = 2'b00,
		ICS_TAG_STAT = 2'b01,
		ICS_TAG_SERV = 2'b10
	} ics_tag_e;

	// Reverse bit order: line 0 carries the most significant bit
	function automatic logic [7:0] ics_swap(input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7 - i];
		end
		return r;
	endfunction : ics_swap
endpackage : ics_pkg

/* File: hdl/ics_unit.sv */
`timescale 1ns/10ps
module ics_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;

	// Honest full and empty from occupancy
	assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rd_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end

	// Pointers wrap because depth is a power of two
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= rd_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : ics_fifo

module ics_unit (
	input  wire logic                      clk_sys,
	input  wire logic                      rst,
	input  wire logic [7:0]                unit_addr,
	input  wire logic                      chain_in_return,
	input  wire logic                      busy,
	input  wire logic [ics_pkg::ICS_FIFO_WIDTH-1:0] tx_data,
	input  wire logic                      tx_valid,
	output logic                           tx_ready,
	output logic [7:0]                     tx_status,
	input  wire logic                      tx_status_valid,
	input  wire logic [8:0]                bus_out,
	input  wire logic                      address_out,
	input  wire logic                      command_out,
	input  wire logic                      service_out,
	input  wire logic                      operational_out,
	input  wire logic                      select_out_up,
	input  wire logic                      hold_out,
	input  wire logic                      select_in_up,
	output logic                           select_out_down,
	output logic                           select_in_down,
	output logic [8:0]                     bus_in,
	output logic                           operational_in,
	output logic                           address_in,
	output logic                           status_in,
	output logic                           service_in,
	output logic                           request_in,
	output logic                           parity_error,
	output logic                           disconnect_seen
);
	import ics_pkg::*;

	logic [10:0] s1_reg;
	logic [10:0] s2_reg;
	logic        adr_o;
	logic        cmd_o;
	logic        svc_o;
	logic        sel_chain;
	logic        sel_prev_reg;
	logic        passed_reg;
	logic        claim;
	logic        busy_hit;
	logic        match_reg;
	logic        halt_reg;
	logic        adr_prev_reg;
	logic        out_odd;
	logic [7:0]  out_byte;
	ics_state_e  state_reg;
	ics_tag_e    tag_reg;
	logic [3:0]  setup_reg;
	logic [7:0]  disc_reg;
	logic [7:0]  fifo_data;
	logic        fifo_valid;
	logic        fifo_pop;
	logic [7:0]  in_byte;
	logic        tag_up;

	assign tx_status = ICS_BYTE_ZERO;

	// Two-stage sync on all channel lines
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= {address_out, command_out, service_out, operational_out, select_out_up, hold_out,
			           select_in_up, bus_out[8], 3'h0};
			s2_reg <= s1_reg;
		end
	end

	// Address-out, command-out and service-out only count with operational-out up
	assign adr_o     = s2_reg[10] && s2_reg[7];
	assign cmd_o     = s2_reg[9] && s2_reg[7];
	assign svc_o     = s2_reg[8] && s2_reg[7];
	assign sel_chain = chain_in_return ? s2_reg[4] : s2_reg[6];

	// Bus-out data sync, byte reversed to normal bit order
	logic [7:0] bo1_reg;
	logic [7:0] bo2_reg;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bo1_reg <= ICS_BYTE_ZERO;
			bo2_reg <= ICS_BYTE_ZERO;
		end else begin
			bo1_reg <= bus_out[7:0];
			bo2_reg <= bo1_reg;
		end
	end
	assign out_byte = ics_swap(bo2_reg);
	assign out_odd  = ^{out_byte, s2_reg[3]};

	// Track the poll edge: a fresh rise re-arms claiming
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sel_prev_reg <= 1'b0;
			passed_reg   <= 1'b0;
		end else begin
			sel_prev_reg <= sel_chain;
			if (sel_chain && !sel_prev_reg) begin
				passed_reg <= !claim;
			end else if (!sel_chain) begin
				passed_reg <= 1'b0;
			end
		end
	end

	// Claim on own request or on a matching, idle address
	assign claim = s2_reg[5] && sel_chain && !passed_reg && state_reg == ICS_IDLE && (fifo_valid || match_reg)
	               && !halt_reg;

	// Busy unit seeing its address keeps select-out, or select-in would race status-in
	assign busy_hit = adr_o && out_odd && out_byte == unit_addr && busy && sel_chain && s2_reg[5];

	// Address decode while address-out stands
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			match_reg    <= 1'b0;
			halt_reg     <= 1'b0;
			adr_prev_reg <= 1'b0;
		end else begin
			match_reg    <= adr_o && out_odd && out_byte == unit_addr && !busy;
			// Only a fresh address-out under op-in is a halt; the selecting one lingers in the sync
			adr_prev_reg <= adr_o;
			halt_reg     <= adr_o && !adr_prev_reg && operational_in;
		end
	end

	// Connection sequencer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= ICS_IDLE;
			tag_reg   <= ICS_TAG_ADDR;
			setup_reg <= ICS_CNT_ZERO;
			disc_reg  <= ICS_BYTE_ZERO;
		end else begin
			case (state_reg)
				ICS_IDLE: begin
					if (claim) begin
						state_reg <= ICS_SETUP;
						tag_reg   <= ICS_TAG_ADDR;
						setup_reg <= ICS_SETUP_CNT;
					end else if (busy_hit) begin
						state_reg <= ICS_SETUP;
						tag_reg   <= ICS_TAG_STAT;
						setup_reg <= ICS_SETUP_CNT;
					end
				end
				ICS_SETUP: begin
					if (setup_reg != ICS_CNT_ZERO) begin
						setup_reg <= setup_reg - 4'h1;
					end else begin
						state_reg <= ICS_TAG;
					end
				end
				ICS_TAG: begin
					if (cmd_o || svc_o || (tag_reg == ICS_TAG_STAT && !sel_chain)) begin
						state_reg <= ICS_WAIT_DROP;
					end
				end
				ICS_WAIT_DROP: begin
					if (!cmd_o && !svc_o) begin
						if (tag_reg != ICS_TAG_STAT && fifo_valid) begin
							state_reg <= ICS_SETUP;
							tag_reg   <= ICS_TAG_SERV;
							setup_reg <= ICS_SETUP_CNT;
						end else begin
							state_reg <= ICS_HOLD;
						end
					end
				end
				ICS_HOLD: begin
					if (!sel_chain) begin
						state_reg <= ICS_IDLE;
					end
				end
				ICS_DISC: begin
					if (disc_reg != ICS_BYTE_ZERO) begin
						disc_reg <= disc_reg - 8'h01;
					end
					if (!sel_chain || disc_reg == ICS_BYTE_ZERO) begin
						state_reg <= ICS_IDLE;
					end
				end
				default: begin
					state_reg <= ICS_IDLE;
				end
			endcase
			if (halt_reg && state_reg != ICS_IDLE && state_reg != ICS_DISC) begin
				state_reg <= ICS_DISC;
				disc_reg  <= ICS_DISC_CNT;
			end
			if (!s2_reg[7]) begin
				state_reg <= ICS_IDLE;
			end
		end
	end

	// Pop a data byte when the channel takes it
	assign fifo_pop = state_reg == ICS_TAG && tag_reg == ICS_TAG_SERV && svc_o;
	assign in_byte  = (tag_reg == ICS_TAG_ADDR) ? unit_addr : (tag_reg == ICS_TAG_STAT) ? tx_status : fifo_data;
	assign tag_up   = state_reg == ICS_TAG;

	ics_fifo #(
		.WIDTH (ICS_FIFO_WIDTH),
		.DEPTH (ICS_FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_data   (tx_data),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	// Registered pins; bus-in is loaded before its tag rises
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus_in          <= 9'h001;
			operational_in  <= 1'b0;
			address_in      <= 1'b0;
			status_in       <= 1'b0;
			service_in      <= 1'b0;
			request_in      <= 1'b0;
			select_out_down <= 1'b0;
			select_in_down  <= 1'b0;
			parity_error    <= 1'b0;
			disconnect_seen <= 1'b0;
		end else begin
			if (state_reg == ICS_SETUP) begin
				bus_in <= {~^in_byte, ics_swap(in_byte)};
			end
			operational_in  <= state_reg != ICS_IDLE && tag_reg != ICS_TAG_STAT;
			address_in      <= tag_up && tag_reg == ICS_TAG_ADDR;
			status_in       <= tag_up && tag_reg == ICS_TAG_STAT;
			service_in      <= tag_up && tag_reg == ICS_TAG_SERV;
			request_in      <= fifo_valid && state_reg == ICS_IDLE;
			select_out_down <= chain_in_return ? s2_reg[6] :
			                   (s2_reg[6] && state_reg == ICS_IDLE && !claim && !busy_hit);
			select_in_down  <= chain_in_return ? (s2_reg[4] && state_reg == ICS_IDLE && !claim && !busy_hit) :
			                   s2_reg[4];
			parity_error    <= (adr_o || (svc_o && tag_reg == ICS_TAG_SERV)) && !out_odd;
			disconnect_seen <= halt_reg;
		end
	end
endmodule : ics_unit

/* File: dv/ics_unit_assertions.sv */
`timescale 1ns/10ps
module ics_unit_chk (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       chain_in_return,
	input wire logic       operational_out,
	input wire logic       select_out_up,
	input wire logic       hold_out,
	input wire logic       select_out_down,
	input wire logic [8:0] bus_in,
	input wire logic       operational_in,
	input wire logic       address_in,
	input wire logic       status_in,
	input wire logic       service_in,
	input wire logic       disconnect_seen
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Interface checks, all in the system clock domain
	a_bus_in_odd: assert property (^bus_in) else $error("bus_in parity even");
	a_in_tag_one: assert property ($onehot0({address_in, status_in, service_in})) else $error("two in tags");
	a_opin_hold: assert property ($fell(operational_in) |-> !$past(select_out_up, 2))
		else $error("op-in fell under select-out");
	a_hold_gates: assert property ((!hold_out) [*8] |-> !$rose(operational_in)) else $error("claim without hold");
	a_opout_gate: assert property ((!operational_out) [*4] |-> !(address_in || status_in || service_in))
		else $error("tag while gated");
	a_fwd_delay: assert property ((!hold_out && !chain_in_return && !operational_in) [*4] |->
		select_out_down == $past(select_out_up, 3)) else $error("select-out not forwarded");
	a_claim_block: assert property (operational_in |-> !select_out_down) else $error("select leaks");
	a_disc_bound: assert property ($rose(disconnect_seen) |-> ##[0:60] !operational_in)
		else $error("disconnect too slow");
endmodule : ics_unit_chk
bind ics_unit ics_unit_chk ics_unit_chk_inst (.*);

/* File: dv/ics_chan.sv */
`timescale 1ns/10ps
module ics_chan (
	input  wire logic       clk_sys,
	input  wire logic       select_in,
	input  wire logic [8:0] bus_in,
	input  wire logic       operational_in,
	input  wire logic       address_in,
	input  wire logic       status_in,
	input  wire logic       service_in,
	output logic      [8:0] bus_out,
	output logic            address_out,
	output logic            command_out,
	output logic            service_out,
	output logic            operational_out,
	output logic            select_out_up,
	output logic            hold_out
);
	logic [8:0] rx[$];
	int         k;
	// Idle channel, bus holds a valid odd byte
	initial begin
		{address_out, command_out, service_out, operational_out, select_out_up, hold_out} = 6'h00;
		bus_out = 9'h1a5;
	end
	// Gate and hold-out levels, then let the unit settle
	task automatic ctl(input logic op, input logic hold);
		operational_out = op;
		hold_out = hold;
		repeat (4) @(negedge clk_sys);
	endtask : ctl
	// Scan; slow stalls each data byte, bytes land in rx
	task automatic poll(input int n, input logic slow);
		rx.delete();
		select_out_up = 1'b1;
		k = 0;
		while (!address_in && !select_in && k++ < 300) @(negedge clk_sys);
		if (address_in) begin
			rx.push_back(bus_in);
			command_out = 1'b1;
			while (address_in && k++ < 300) @(negedge clk_sys);
			command_out = 1'b0;
			while (rx.size() < n && k++ < 3000) begin
				@(negedge clk_sys);
				if (service_in) begin
					repeat (slow ? 6 : 1) @(negedge clk_sys);
					rx.push_back(bus_in);
					service_out = 1'b1;
					while (service_in && k++ < 3000) @(negedge clk_sys);
					service_out = 1'b0;
				end
			end
		end
		select_out_up = 1'b0;
		while ((operational_in || select_in) && k++ < 3000) @(negedge clk_sys);
	endtask : poll
	// Selection by address; r is {op-in, status-in, select-in}
	task automatic sel(input logic [8:0] b, output logic [2:0] r);
		bus_out = b;
		address_out = 1'b1;
		repeat (4) @(negedge clk_sys);
		select_out_up = 1'b1;
		k = 0;
		while (!(operational_in || status_in || select_in) && k++ < 300) @(negedge clk_sys);
		r = {operational_in, status_in, select_in};
		if (status_in) begin
			select_out_up = 1'b0;
			while (status_in && k++ < 300) @(negedge clk_sys);
		end
		address_out = 1'b0;
		bus_out = ~b;
		if (operational_in) begin
			while (!address_in && k++ < 300) @(negedge clk_sys);
			command_out = 1'b1;
			while (address_in && k++ < 300) @(negedge clk_sys);
			command_out = 1'b0;
		end else begin
			select_out_up = 1'b0;
		end
		repeat (4) @(negedge clk_sys);
	endtask : sel
	// Halt: address-out held until op-in falls; c counts the wait
	task automatic halt(output int c);
		bus_out = ~bus_out;
		address_out = 1'b1;
		select_out_up = 1'b0;
		c = 0;
		while (operational_in && c++ < 300) @(negedge clk_sys);
		address_out = 1'b0;
	endtask : halt
endmodule : ics_chan

/* File: dv/tb.sv */
`timescale 1ns/10ps
module tb;
	import ics_pkg::*;
	localparam logic [7:0] UA = 8'h5c;
	logic       clk_sys, rst, busy, tx_valid, tx_ready, perr_seen, parity_error, disconnect_seen, disc_seen;
	logic       select_in, select_out_down, operational_in, address_in, status_in, service_in, request_in;
	logic       address_out, command_out, service_out, operational_out, select_out_up, hold_out;
	logic [7:0] tx_data;
	logic [8:0] bus_out, bus_in;
	logic [2:0] r;
	int         fails, comparisons, c;
	// Last unit in the chain: its select-out returns as select-in
	ics_unit ics_unit_inst (.clk_sys, .rst, .unit_addr(UA), .chain_in_return(1'b0), .busy, .tx_data, .tx_valid,
		.tx_ready, .tx_status(), .tx_status_valid(1'b0), .bus_out, .address_out, .command_out, .service_out,
		.operational_out, .select_out_up, .hold_out, .select_in_up(select_out_down), .select_out_down,
		.select_in_down(select_in), .bus_in, .operational_in, .address_in, .status_in, .service_in, .request_in,
		.parity_error, .disconnect_seen);
	ics_chan ics_chan_inst (.clk_sys, .select_in, .bus_in, .operational_in, .address_in, .status_in, .service_in,
		.bus_out, .address_out, .command_out, .service_out, .operational_out, .select_out_up, .hold_out);
	// 10 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Sticky parity flag, cleared by the scenario that needs it
	always @(posedge clk_sys) if (parity_error === 1'b1) perr_seen <= 1'b1;
	// Sticky disconnect flag, the pulse is too short to catch otherwise
	always @(posedge clk_sys) if (disconnect_seen === 1'b1) disc_seen <= 1'b1;
	// Byte to bus lines: reversed order, odd parity on top
	function automatic logic [8:0] enc(input logic [7:0] b);
		for (int i = 0; i < 8; i++) enc[i] = b[7 - i];
		enc[8] = ~^b;
	endfunction : enc
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic end_of_test();
		if (fails == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	// Fill buffer past full, forward without hold-out, then drain with stalls
	task automatic t_fill();
		for (int i = 0; i < 33; i++) begin
			tx_data = (i < 32) ? 8'(i) : 8'hff;
			tx_valid = 1'b1;
			@(negedge clk_sys);
		end
		tx_valid = 1'b0;
		check("full", tx_ready, 1'b0);
		check("req", request_in, 1'b1);
		ics_chan_inst.ctl(1'b1, 1'b0);
		ics_chan_inst.poll(33, 1'b0);
		check("fwd", ics_chan_inst.rx.size(), 0);
		ics_chan_inst.ctl(1'b1, 1'b1);
		ics_chan_inst.poll(33, 1'b1);
		check("addr", ics_chan_inst.rx[0], enc(UA));
		for (int i = 0; i < 32; i++) check("data", ics_chan_inst.rx[i + 1], enc(8'(i)));
		check("req", request_in, 1'b0);
	endtask : t_fill
	// Selection: match, halt, busy, other address, bad parity, gate low
	task automatic t_sel();
		ics_chan_inst.sel(enc(UA), r);
		check("sel", r, 3'b100);
		check("nodisc", disc_seen, 1'b0);
		ics_chan_inst.halt(c);
		check("halt", c <= 64, 1'b1);
		repeat (2) @(negedge clk_sys);
		check("disc", disc_seen, 1'b1);
		busy = 1'b1;
		ics_chan_inst.sel(enc(UA), r);
		check("busy", r, 3'b010);
		busy = 1'b0;
		perr_seen = 1'b0;
		ics_chan_inst.sel(enc(~UA), r);
		check("other", {r, perr_seen}, 4'h2);
		ics_chan_inst.sel(enc(UA) ^ 9'h100, r);
		check("perr", {r, perr_seen}, 4'h3);
		ics_chan_inst.ctl(1'b0, 1'b1);
		ics_chan_inst.sel(enc(UA), r);
		check("gated", r[2:1], 2'b00);
	endtask : t_sel
	initial begin
		rst = 1'b1;
		busy = 1'b0;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		perr_seen = 1'b0;
		disc_seen = 1'b0;
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		check("bus_in", bus_in, 9'h001);
		ics_chan_inst.ctl(1'b1, 1'b1);
		t_fill();
		t_sel();
		end_of_test();
	end
	// Watchdog well beyond the several hundred cycles needed
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		end_of_test();
	end
endmodule : tb
